// ### src/sfo_cfg.svh
// Constants for the supply fault/output configuration register bank.
// Assumes inclusion by the design modules only.
`ifndef SFO_CFG_SVH
`define SFO_CFG_SVH

// ==================================================
// Register offsets
`define SFO_OFS_CFG6       8'h12
`define SFO_OFS_CFG7       8'h13
`define SFO_OFS_DIV_TRIM   8'h14
`define SFO_OFS_AMP_TRIM   8'h15
`define SFO_OFS_CS_OPT1    8'h16

// ==================================================
// Reset values (loaded while sys_rst is high)
`define SFO_RST_CFG6       8'h00
`define SFO_RST_CFG7       8'h00
`define SFO_RST_TRIM       8'h00
`define SFO_RST_CS_OPT1    8'h00
`define SFO_RDATA_NONE     8'h00

// ==================================================
// Read masks: write-only bits read as zero
`define SFO_RDMASK_CFG6    8'hd9
`define SFO_RDMASK_CFG7    8'hfb
// Latch-clear bit is a command and never stored
`define SFO_STMASK_CFG7    8'hfe
`define SFO_BIT_LATCH_CLR  0
// Polarised status outputs sharing one polarity scheme
`define SFO_POL_LANES      4

// ==================================================
// Timing
`define SFO_CLK_HZ         25000000
`define SFO_CLK_MHZ        25
`define SFO_SHORT_UNIT_US  128
`define SFO_LONG_UNIT_S    1
`define SFO_SHORT_UNIT_CYC (`SFO_SHORT_UNIT_US * `SFO_CLK_MHZ)
`define SFO_LONG_UNIT_CYC  (`SFO_LONG_UNIT_S * `SFO_CLK_HZ)
`define SFO_CNT_W          32
`define SFO_CNT_ZERO       32'h0000_0000
`define SFO_CNT_ONE        32'h0000_0001

`endif

// ### src/sfo_pkg.sv
// Types shared by the configuration register bank and its timer.
// Assumes sfo_cfg.svh is on the include path.
package sfo_pkg;

  // ==================================================
  // Timer states, Gray along idle -> run -> expired
  typedef enum logic [1:0] {
    SFO_RT_IDLE    = 2'b00,
    SFO_RT_RUN     = 2'b01,
    SFO_RT_EXPIRED = 2'b11
  } sfo_rt_st_e;

  typedef struct packed {
    sfo_rt_st_e       st;
    logic [31:0]      cnt;
    logic             expired;
  } sfo_rt_s;

  // ==================================================
  // Ridethrough_ac_share_config fields
  typedef struct packed {
    logic       restart_mode;
    logic       mcu_ac_gate_mode;
    logic       mcu_ac_sense;
    logic [1:0] ridethrough_period_sel;
    logic       ac_sense_source;
    logic       mcu_power_on;
    logic       share_clamp_threshold;
  } sfo_cfg6_s;

  // Status_output_polarity_host_ctrl fields
  typedef struct packed {
    logic power_enable_polarity_hi;
    logic fault_out_polarity_hi;
    logic dc_good_polarity_hi;
    logic ac_good_polarity_hi;
    logic iso_gate_polarity;
    logic host_share_clamp;
    logic host_fault_drive;
    logic host_latch_clear;
  } sfo_cfg7_s;

  // Current sense options 1 fields
  typedef struct packed {
    logic [1:0] unused_sense_bits;
    logic [2:0] divider_trim_range;
    logic [2:0] sense_gain_sel;
  } sfo_csopt_s;

  // ==================================================
  // Register write port
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfo_wr_s;

  // Registered status outputs, the first five polarity-corrected
  typedef struct packed {
    logic power_enable_output;
    logic fault_out;
    logic dc_good_output;
    logic ac_good_output;
    logic iso_gate_drive;
    logic share_clamp;
    logic share_clamp_release_88;
    logic overcurrent_timeout;
  } sfo_out_s;

  // Settings handed to the analog trims
  typedef struct packed {
    logic [7:0] divider_offset_trim;
    logic [7:0] amp_offset_trim;
    sfo_csopt_s cs_opt;
  } sfo_trim_s;

endpackage

// ### src/sfo_ridethrough_timer.sv
// Overcurrent ride-through timer.
// Assumes oc_active is already synchronous to mclk.
`timescale 1ns/1ps
`include "sfo_cfg.svh"

module sfo_ridethrough_timer
  import sfo_pkg::*;
#(
  parameter logic [31:0] SEC_CYCLES = `SFO_LONG_UNIT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       oc_active,
  input  wire logic       short_sel,
  input  wire logic [1:0] period_sel,
  output logic            expired
);

  sfo_rt_s     r;
  sfo_rt_s     next_r;
  logic [31:0] unit;
  logic [31:0] period;

  // ==================================================
  // Period select
  always_comb begin
    unit   = short_sel ? 32'(`SFO_SHORT_UNIT_CYC) : SEC_CYCLES;
    period = 32'(unit * ({30'h0, period_sel} + 32'h1));
  end

  // ==================================================
  // Timer
  always_comb begin
    next_r = r;
    unique case (r.st)
      SFO_RT_IDLE: begin
        next_r.cnt = `SFO_CNT_ZERO;
        if (oc_active) begin
          next_r.st  = SFO_RT_RUN;
          next_r.cnt = `SFO_CNT_ONE;
        end
      end
      SFO_RT_RUN: begin
        if (!oc_active) begin
          next_r.st = SFO_RT_IDLE;
        end else if (r.cnt >= period - `SFO_CNT_ONE) begin
          next_r.st = SFO_RT_EXPIRED;
        end else begin
          next_r.cnt = r.cnt + `SFO_CNT_ONE;
        end
      end
      SFO_RT_EXPIRED: begin
        if (!oc_active) begin
          next_r.st = SFO_RT_IDLE;
        end
      end
      default: begin
        next_r.st = SFO_RT_IDLE;
      end
    endcase
    next_r.expired = (next_r.st == SFO_RT_EXPIRED);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '{st: SFO_RT_IDLE, cnt: `SFO_CNT_ZERO, expired: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign expired = r.expired;

endmodule

// ### src/sfo_config_regs.sv
// Fault/output configuration registers of a supply secondary controller.
// Assumes a register port already decoded from the management interface.
//
// Summary of operation
// - Short select clear: period code picks 1, 2, 3 or 4 seconds.
// - Short select set: period code picks 128, 256, 384 or 512 us.
// - Write-only source bit picks AC sense input 1 or 2 for AC-good.
// - Polarity bits with companion bits set POWER_ENABLE_OUTPUT, fault, DC-good, AC-good levels.
// - Isolation gate polarity 0 inverts gate drive, low turns switch on.
// - Host clamp bit 1 forces share clamp; 0 returns to internal control.
// - Host fault-drive bit 1 forces fault indicator asserted; 0 leaves it to the fault logic.
// - Host latch-clear command releases the latched fault indicator.
// - Latch mode 0 makes fault indicator non-latching, 1 latching.
// - Eight-bit divider offset trim cancels external divider common-mode offset.
// - Eight-bit amplifier offset trim cancels sense amplifier DC offset.
`timescale 1ns/1ps
`include "sfo_cfg.svh"

module sfo_config_regs
  import sfo_pkg::*;
#(
  parameter logic [31:0] SEC_CYCLES = `SFO_LONG_UNIT_CYC
) (
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire sfo_wr_s   reg_wr,
  input  wire logic[7:0] reg_raddr,
  output logic     [7:0] reg_rdata,
  input  wire logic      short_ridethrough_sel,
  input  wire logic      fault_latch_mode,
  input  wire logic      power_enable_polarity_lo,
  input  wire logic      fault_out_polarity_lo,
  input  wire logic      dc_good_polarity_lo,
  input  wire logic      ac_good_polarity_lo,
  input  wire logic      overcurrent_protection,
  input  wire logic      fault_event,
  input  wire logic      ac_sense1,
  input  wire logic      ac_sense2,
  input  wire logic      power_enable_raw,
  input  wire logic      dc_good_raw,
  input  wire logic      iso_gate_on,
  input  wire logic      share_clamp_internal,
  output sfo_out_s       status_out,
  output sfo_trim_s      trim_out,
  output logic     [7:0] cfg6_out
);

  // ==================================================
  // Module state
  typedef struct packed {
    sfo_cfg6_s  cfg6;
    sfo_cfg7_s  cfg7;
    logic [7:0] div_trim;
    logic [7:0] amp_trim;
    sfo_csopt_s cs_opt;
    logic       fault_latched;
    logic [7:0] rdata;
    sfo_out_s   o;
  } sfo_regs_s;

  sfo_regs_s  r;
  sfo_regs_s  next_r;
  logic       oc_timeout;
  logic       wr_cfg6;
  logic       wr_cfg7;
  logic       wr_div;
  logic       wr_amp;
  logic       wr_cso;
  logic       fault_clr;
  logic       fault_src;
  logic       fault_raw;
  logic       ac_raw;
  logic [3:0] pol_raw;
  logic [3:0] pol_hi;
  logic [3:0] pol_lo;
  logic [3:0] pol_out;

  // ==================================================
  // Ride-through timer
  // Short select is host owned; zero ride-through still leaves one unit
  sfo_ridethrough_timer #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_rt (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .oc_active  (overcurrent_protection),
    .short_sel  (short_ridethrough_sel),
    .period_sel (r.cfg6.ridethrough_period_sel),
    .expired    (oc_timeout)
  );

  // ==================================================
  // Write strobes; unmapped offsets raise none and are dropped
  assign wr_cfg6   = reg_wr.wr && (reg_wr.addr == `SFO_OFS_CFG6);
  assign wr_cfg7   = reg_wr.wr && (reg_wr.addr == `SFO_OFS_CFG7);
  assign wr_div    = reg_wr.wr && (reg_wr.addr == `SFO_OFS_DIV_TRIM);
  assign wr_amp    = reg_wr.wr && (reg_wr.addr == `SFO_OFS_AMP_TRIM);
  assign wr_cso    = reg_wr.wr && (reg_wr.addr == `SFO_OFS_CS_OPT1);
  // Latch clear is a command bit; it acts on the write edge only
  assign fault_clr = wr_cfg7 && reg_wr.wdata[`SFO_BIT_LATCH_CLR];
  assign fault_src = oc_timeout | fault_event;

  // ==================================================
  // Raw levels ahead of polarity
  assign fault_raw = (fault_latch_mode ? r.fault_latched : fault_src)
                   | r.cfg7.host_fault_drive;
  assign ac_raw    = r.cfg6.ac_sense_source ? ac_sense2 : ac_sense1;

  // ==================================================
  // Output polarity, one lane per polarised status output
  assign pol_raw = {power_enable_raw, fault_raw, dc_good_raw, ac_raw};
  assign pol_hi  = {r.cfg7.power_enable_polarity_hi, r.cfg7.fault_out_polarity_hi,
                    r.cfg7.dc_good_polarity_hi, r.cfg7.ac_good_polarity_hi};
  assign pol_lo  = {power_enable_polarity_lo, fault_out_polarity_lo,
                    dc_good_polarity_lo, ac_good_polarity_lo};

  for (genvar g = 0; g < `SFO_POL_LANES; g++) begin : g_pol
    // Active high only when the two polarity bits disagree
    assign pol_out[g] = pol_raw[g] ^ ~(pol_hi[g] ^ pol_lo[g]);
  end

  // ==================================================
  // Next state
  always_comb begin
    next_r = r;
    if (wr_cfg6) begin
      next_r.cfg6 = sfo_cfg6_s'(reg_wr.wdata);
    end
    if (wr_cfg7) begin
      // Clear command masked off so it is never stored
      next_r.cfg7 = sfo_cfg7_s'(reg_wr.wdata & `SFO_STMASK_CFG7);
    end
    if (wr_div) begin
      next_r.div_trim = reg_wr.wdata;
    end
    if (wr_amp) begin
      next_r.amp_trim = reg_wr.wdata;
    end
    if (wr_cso) begin
      next_r.cs_opt = sfo_csopt_s'(reg_wr.wdata);
    end

    // Clear before set so a fault in the clear cycle survives
    if (!fault_latch_mode) begin
      next_r.fault_latched = 1'b0;
    end else begin
      if (fault_clr) begin
        next_r.fault_latched = 1'b0;
      end
      if (fault_src) begin
        next_r.fault_latched = 1'b1;
      end
    end

    {next_r.o.power_enable_output, next_r.o.fault_out,
     next_r.o.dc_good_output, next_r.o.ac_good_output} = pol_out;
    next_r.o.iso_gate_drive = iso_gate_on ^ ~r.cfg7.iso_gate_polarity;
    next_r.o.share_clamp = r.cfg7.host_share_clamp | share_clamp_internal;
    next_r.o.share_clamp_release_88 = r.cfg6.share_clamp_threshold;
    next_r.o.overcurrent_timeout = oc_timeout;

    // ==================================================
    // Read data, registered one cycle after the address
    unique case (reg_raddr)
      `SFO_OFS_CFG6:     next_r.rdata = 8'(r.cfg6) & `SFO_RDMASK_CFG6;
      `SFO_OFS_CFG7:     next_r.rdata = 8'(r.cfg7) & `SFO_RDMASK_CFG7;
      `SFO_OFS_DIV_TRIM: next_r.rdata = r.div_trim;
      `SFO_OFS_AMP_TRIM: next_r.rdata = r.amp_trim;
      `SFO_OFS_CS_OPT1:  next_r.rdata = 8'(r.cs_opt);
      default:           next_r.rdata = `SFO_RDATA_NONE;
    endcase
  end

  // ==================================================
  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '{cfg6:          sfo_cfg6_s'(`SFO_RST_CFG6),
             cfg7:          sfo_cfg7_s'(`SFO_RST_CFG7),
             div_trim:      `SFO_RST_TRIM,
             amp_trim:      `SFO_RST_TRIM,
             cs_opt:        sfo_csopt_s'(`SFO_RST_CS_OPT1),
             fault_latched: 1'b0,
             rdata:         `SFO_RDATA_NONE,
             o:             '0};
    end else begin
      r <= next_r;
    end
  end

  // ==================================================
  // Outputs
  assign reg_rdata  = r.rdata;
  assign status_out = r.o;
  assign cfg6_out   = 8'(r.cfg6);
  assign trim_out   = '{divider_offset_trim: r.div_trim,
                        amp_offset_trim:     r.amp_trim,
                        cs_opt:              r.cs_opt};

endmodule

// ### verif/sfo_config_regs_properties.sv
// Assertions on the config register bank ports.
// Assumes a bind onto sfo_config_regs and one clock domain.
`timescale 1ns/1ps
module sfo_config_regs_properties
  import sfo_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire sfo_wr_s    reg_wr,
  input wire logic [7:0] reg_raddr,
  input wire logic [7:0] reg_rdata,
  input wire logic       overcurrent_protection,
  input wire logic       share_clamp_internal,
  input wire sfo_out_s   status_out,
  input wire sfo_trim_s  trim_out,
  input wire logic [7:0] cfg6_out
);
  // ====
  // Port relations
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [7:0] a);
    reg_wr.wr && reg_wr.addr == a;
  endsequence
  // Two quiet cycles so the registered output has caught up
  sequence s_thr_held;
    $stable(cfg6_out[0]) [*2];
  endsequence
  a_div_trim_store: assert property (
    s_wr(8'h14) |=> trim_out.divider_offset_trim == $past(reg_wr.wdata))
    else $error("divider trim not stored");
  a_amp_trim_store: assert property (
    s_wr(8'h15) |=> trim_out.amp_offset_trim == $past(reg_wr.wdata))
    else $error("amp trim not stored");
  a_amp_trim_read: assert property (
    reg_raddr == 8'h15 |=> reg_rdata == $past(trim_out.amp_offset_trim))
    else $error("amp trim readback wrong");
  a_cfg6_store: assert property (
    s_wr(8'h12) |=> cfg6_out == $past(reg_wr.wdata))
    else $error("ridethrough_ac_share_config not stored");
  a_cfg6_read_mask: assert property (
    reg_raddr == 8'h12 |=> reg_rdata == ($past(cfg6_out) & 8'hd9))
    else $error("ridethrough_ac_share_config write-only bits visible");
  a_clamp_forced: assert property (
    share_clamp_internal |=> status_out.share_clamp)
    else $error("share clamp not asserted");
  a_timeout_needs_oc: assert property (
    status_out.overcurrent_timeout |->
      $past(overcurrent_protection) || $past(overcurrent_protection, 2))
    else $error("timeout without overcurrent");
  a_release_thr: assert property (
    s_thr_held |-> status_out.share_clamp_release_88 == cfg6_out[0])
    else $error("clamp release point wrong");
endmodule

bind sfo_config_regs sfo_config_regs_properties i_props (.mclk, .sys_rst, .reg_wr,
  .reg_raddr, .reg_rdata, .overcurrent_protection, .share_clamp_internal, .status_out,
  .trim_out, .cfg6_out);

// ### verif/sfo_host_model.sv
// Host model: drives the register port at the falling edge.
// Assumes a free-running mclk and a registered read port.
`timescale 1ns/1ps
module sfo_host_model
  import sfo_pkg::*;
(
  input  wire logic [7:0] reg_rdata,
  input  wire logic       mclk,
  output sfo_wr_s         reg_wr,
  output logic      [7:0] reg_raddr
);
  // ====
  // Bus tasks
  initial begin
    reg_wr = '0;
    reg_raddr = 8'h00;
  end
  // Released fields are scrambled so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk);
    reg_wr = '{wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_raddr = a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule

// ### verif/tb_sfo_config_regs.sv
// Bench for the config register bank: registers, timer and outputs.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module tb_sfo_config_regs;
  import sfo_pkg::*;
  logic       mclk = 1'b0;
  logic       sys_rst, ss, lm, pl, oc, fe, ci, ig, inv;
  logic [7:0] rdata, raddr, rv, cfg6;
  sfo_wr_s    wr;
  sfo_out_s   st;
  sfo_trim_s  trim;
  int         failures, checked, cyc, k;
  logic [7:0] ta [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h20};
  logic [7:0] td [6] = '{8'hff, 8'hff, 8'h5a, 8'ha5, 8'hc3, 8'h77};
  logic [7:0] te [6] = '{8'hd9, 8'hfa, 8'h5a, 8'ha5, 8'hc3, 8'h00};
  // ====
  // Clock, host and design
  always #20 mclk = ~mclk;
  sfo_host_model u_host (.mclk, .reg_rdata(rdata), .reg_wr(wr), .reg_raddr(raddr));
  // Long unit cut to 100 cycles to keep second periods short
  sfo_config_regs #(.SEC_CYCLES(32'd100)) i_sfo_config_regs (.mclk, .sys_rst,
    .reg_wr(wr), .reg_raddr(raddr), .reg_rdata(rdata), .short_ridethrough_sel(ss),
    .fault_latch_mode(lm), .power_enable_polarity_lo(pl), .fault_out_polarity_lo(pl),
    .dc_good_polarity_lo(pl), .ac_good_polarity_lo(pl), .overcurrent_protection(oc),
    .fault_event(fe), .ac_sense1(1'b1), .ac_sense2(1'b0), .power_enable_raw(1'b1),
    .dc_good_raw(1'b1), .iso_gate_on(ig), .share_clamp_internal(ci),
    .status_out(st), .trim_out(trim), .cfg6_out(cfg6));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ws(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    repeat (3) @(negedge mclk);
  endtask
  task automatic rt(input logic [1:0] c, input logic s, input int n, input int pre);
    ws(8'h12, {3'b000, c, 3'b000});
    ss = s;
    oc = (pre > 0);
    repeat (pre) @(negedge mclk);
    chk(st.overcurrent_timeout, 1'b0);
    oc = 1'b0;
    repeat (3) @(negedge mclk);
    oc = 1'b1;
    k = 0;
    while (st.overcurrent_timeout !== 1'b1 && k < 20000) begin
      @(negedge mclk);
      k++;
    end
    chk(24'(k), 24'(n + 1));
    oc = 1'b0;
    repeat (3) @(negedge mclk);
    chk(st.overcurrent_timeout, 1'b0);
  endtask
  task automatic final_report();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end
  // ====
  // Test sequence
  initial begin
    {sys_rst, ss, lm, pl, oc, fe, ci, ig} = 8'h80;
    failures = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      u_host.rd(8'h11 + 8'(i), rv);
      chk(rv, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      u_host.wr(ta[i], td[i]);
      u_host.rd(ta[i], rv);
      chk(rv, te[i]);
    end
    chk(trim, 24'h5aa5c3);
    chk(cfg6, 8'hff);
    ws(8'h12, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pl = i[0];
      ig = i[0];
      ws(8'h13, {{5{i[1]}}, 3'b000});
      inv = ~(i[1] ^ i[0]);
      chk({st.power_enable_output, st.fault_out, st.dc_good_output, st.ac_good_output,
        st.iso_gate_drive}, {~inv, inv, ~inv, ~inv, (i[1] ? i[0] : ~i[0])});
    end
    pl = 1'b0;
    ws(8'h13, 8'hfc);
    chk(st.share_clamp, 1'b1);
    ws(8'h13, 8'hf8);
    chk(st.share_clamp, 1'b0);
    ci = 1'b1;
    ws(8'h12, 8'h05);
    chk({st.share_clamp, st.share_clamp_release_88, st.ac_good_output}, 3'b110);
    ci = 1'b0;
    ws(8'h12, 8'h00);
    chk({st.share_clamp, st.share_clamp_release_88, st.ac_good_output}, 3'b001);
    ws(8'h13, 8'hfa);
    chk(st.fault_out, 1'b1);
    for (int m = 0; m < 2; m++) begin
      lm = m[0];
      ws(8'h13, 8'hf8);
      @(negedge mclk) fe = 1'b1;
      @(negedge mclk) fe = 1'b0;
      repeat (3) @(negedge mclk);
      chk(st.fault_out, m[0]);
    end
    ws(8'h13, 8'hf9);
    chk(st.fault_out, 1'b0);
    // Fault pulse in the very cycle of the clear: the set must win
    fork
      u_host.wr(8'h13, 8'hf9);
      begin
        @(negedge mclk) fe = 1'b1;
        @(negedge mclk) fe = 1'b0;
      end
    join
    repeat (3) @(negedge mclk);
    chk(st.fault_out, 1'b1);
    lm = 1'b0;
    rt(2'd1, 1'b1, 6400, 0);
    rt(2'd3, 1'b0, 400, 0);
    rt(2'd0, 1'b0, 100, 90);
    rt(2'd0, 1'b1, 3200, 0);
    // Mid-run reset must clear the stored divider offset trim again
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    u_host.rd(8'h14, rv);
    chk({rv, trim.divider_offset_trim}, 16'h0000);
    final_report();
  end
endmodule
